//--- hw/sat_pkg.sv
// shared constants, address table and decode helpers for the alert bus block
package sat_pkg;

  // ******************************************************
  // clock and bus timing
  // ******************************************************
  localparam int CLK_KHZ = 25000;
  localparam int SCL_KHZ = 100;
  localparam int SCL_MIN_KHZ = 10;
  localparam int SCL_MAX_KHZ = 400;
  localparam int HALF_CYC = CLK_KHZ / (2 * SCL_KHZ);
  localparam int QTR_CYC = HALF_CYC / 2;
  localparam int TIMEOUT_MS = 25;
  localparam int RESET_MAX_MS = 35;
  localparam int TARGET_EXT_MS = 25;
  localparam int HOST_EXT_MS = 10;
  localparam int TIMEOUT_CYC = TIMEOUT_MS * CLK_KHZ;
  localparam int TARGET_EXT_CYC = TARGET_EXT_MS * CLK_KHZ;
  localparam int HOST_EXT_CYC = HOST_EXT_MS * CLK_KHZ;
  localparam int CNT_W = 20;
  localparam int HCNT_W = 8;

  // ******************************************************
  // bus commands, addresses and reset values
  // ******************************************************
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_ALERT_MASK = 8'hd8;
  localparam logic [6:0] ARA_ADDR = 7'h0c;
  localparam logic [15:0] ALERT_MASK_RESET = 16'h0000;
  localparam logic [6:0] TARGET_RESET = 7'h40;
  localparam int FAULT_W = 16;

  // ******************************************************
  // tri-level select pin codes and address table
  // ******************************************************
  localparam logic [1:0] TRI_OPEN = 2'h0;
  localparam logic [1:0] TRI_LOW = 2'h1;
  localparam logic [1:0] TRI_HIGH = 2'h2;
  localparam logic [0:26][6:0] ADDR_TABLE = {
    7'h40, 7'h41, 7'h42, 7'h43, 7'h44, 7'h45, 7'h46, 7'h47, 7'h10,
    7'h11, 7'h12, 7'h13, 7'h14, 7'h15, 7'h16, 7'h17, 7'h50, 7'h51,
    7'h52, 7'h53, 7'h54, 7'h55, 7'h56, 7'h57, 7'h58, 7'h59, 7'h5a};

  // ******************************************************
  // host register map
  // ******************************************************
  localparam logic [7:0] HR_CMD = 8'h00;
  localparam logic [7:0] HR_DATA = 8'h04;
  localparam logic [7:0] HR_TARGET = 8'h08;
  localparam logic [7:0] HR_IRQ_STAT = 8'h0c;
  localparam logic [7:0] HR_IRQ_MASK = 8'h10;
  localparam logic [1:0] OP_CLEAR = 2'h0;
  localparam logic [1:0] OP_MASK = 2'h1;
  localparam logic [1:0] OP_ARA = 2'h2;
  localparam int IRQ_W = 4;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_TIMEOUT = 1;
  localparam int IRQ_ALERT = 2;
  localparam int IRQ_NACK = 3;

  function automatic logic [4:0] tri_val(input logic [1:0] pin);
    tri_val = (pin == TRI_LOW) ? 5'h01 : (pin == TRI_HIGH) ? 5'h02 : 5'h00;
  endfunction

  function automatic logic [6:0] decode_addr(input logic [5:0] pins);
    logic [4:0] idx;
    idx = 5'(tri_val(pins[5:4]) * 5'h09 + tri_val(pins[3:2]) * 5'h03
          + tri_val(pins[1:0]));
    decode_addr = ADDR_TABLE[idx];
  endfunction

endpackage

//--- hw/sat_link_if.sv
// two-wire bus with alert line joining host and target
`timescale 1ns/100ps
interface sat_link_if;
  logic host_scl_oe;
  logic host_sda_oe;
  logic dev_scl_oe;
  logic dev_sda_oe;
  logic dev_alert_oe;
  logic scl;
  logic sda;
  logic alert_out_n;

  // open-drain lines with pull-ups: low while anyone drives
  assign scl = ~(host_scl_oe | dev_scl_oe);
  assign sda = ~(host_sda_oe | dev_sda_oe);
  assign alert_out_n = ~dev_alert_oe;

  modport target (
    input scl,
    input sda,
    input alert_out_n,
    output dev_scl_oe,
    output dev_sda_oe,
    output dev_alert_oe
  );

  modport host (
    input scl,
    input sda,
    input alert_out_n,
    output host_scl_oe,
    output host_sda_oe
  );
endinterface

//--- hw/sat_target.sv
// target end: address decode, alert masking, stretch and clock-low timeouts
// What this block does
// - clock low beyond 25 ms is a timeout
// - timeout abandons bus state within 35 ms
// - target stretching per message stays within 25 ms
// - stretch overrun releases lines, returns to idle
// - host stretch per byte within 10 ms
// - bus clock between 10 and 400 kHz
// - alert gated by software and automatic masks
// - lowest alerting address wins the alert read
// - automatic mask sets only on own win
// - winning sets automatic mask for all faults present, masked or not
// - status keeps showing masked faults
// - automatically masked fault stays quiet until clear-faults
// - host sends clear-faults when servicing alerts
// - address from three tri-level pins, 27 values
//
// The plain strobed port was decided locally.
`timescale 1ns/100ps
module sat_target #(
  parameter int TIMEOUT_CYC = sat_pkg::TIMEOUT_CYC,
  parameter int STRETCH_CYC = sat_pkg::TARGET_EXT_CYC
) (
  input logic clk_in,
  input logic rst_b_in,
  sat_link_if.target link,
  input logic [sat_pkg::FAULT_W-1:0] fault_in,
  input logic busy_in,
  input logic [1:0] addr_sel_pin0_in,
  input logic [1:0] addr_sel_pin1_in,
  input logic [1:0] addr_sel_pin2_in,
  output logic [sat_pkg::FAULT_W-1:0] status_out,
  output logic [sat_pkg::FAULT_W-1:0] alert_mask_out,
  output logic [sat_pkg::FAULT_W-1:0] auto_mask_out,
  output logic [6:0] own_addr_out,
  output logic bus_abort_out
);

  // ******************************************************
  // types and state
  // ******************************************************
  typedef enum logic [5:0] {
    T_IDLE = 6'h01,
    T_ADDR = 6'h02,
    T_ACK = 6'h04,
    T_RX = 6'h08,
    T_TX = 6'h10,
    T_SKIP = 6'h20
  } sat_tstate_type;

  localparam logic [sat_pkg::CNT_W-1:0] TO_LAST =
    sat_pkg::CNT_W'(TIMEOUT_CYC - 1);
  localparam logic [sat_pkg::CNT_W-1:0] EXT_LAST =
    sat_pkg::CNT_W'(STRETCH_CYC - 1);

  logic scl_s1, scl_s2, scl_s3;
  logic sda_s1, sda_s2, sda_s3;
  logic [5:0] pin_s1, pin_s2;
  logic [6:0] own_addr_reg, own_addr_next;
  sat_tstate_type state_reg, state_next, ret_reg, ret_next;
  logic [3:0] bit_reg, bit_next;
  logic [1:0] byte_reg, byte_next;
  logic [7:0] shift_reg, shift_next;
  logic [7:0] cmd_reg, cmd_next;
  logic [7:0] lo_reg, lo_next;
  logic [15:0] mask_reg, mask_next;
  logic [15:0] auto_reg, auto_next;
  logic [15:0] fault_reg, fault_next;
  logic alert_reg, alert_next;
  logic sda_oe_reg, sda_oe_next;
  logic hold_reg, hold_next;
  logic abort_reg, abort_next;
  logic [sat_pkg::CNT_W-1:0] low_reg, low_next;
  logic [sat_pkg::CNT_W-1:0] ext_reg, ext_next;
  logic scl_rise, scl_fall, start_det, stop_det;
  logic to_hit, ext_hit;
  logic [15:0] active;

  // ******************************************************
  // synchronisers for bus lines and select pins
  // ******************************************************
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_s3 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_s3 <= 1'b1;
      pin_s1 <= 6'h00;
      pin_s2 <= 6'h00;
    end else begin
      scl_s1 <= link.scl;
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      sda_s1 <= link.sda;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
      pin_s1 <= {addr_sel_pin2_in, addr_sel_pin1_in, addr_sel_pin0_in};
      pin_s2 <= pin_s1;
    end
  end

  assign scl_rise = scl_s2 & ~scl_s3;
  assign scl_fall = ~scl_s2 & scl_s3;
  assign start_det = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
  assign stop_det = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;

  // ******************************************************
  // timeout and stretch counters
  // ******************************************************
  assign to_hit = ~scl_s2 & (low_reg == TO_LAST);
  assign ext_hit = hold_reg & (ext_reg == EXT_LAST);

  always_comb begin
    low_next = low_reg;
    ext_next = ext_reg;
    if (scl_s2) begin
      low_next = '0;
    end else if (low_reg != TO_LAST + 1'b1) begin
      low_next = low_reg + 1'b1;
    end
    if (start_det) begin
      ext_next = '0;
    end else if (hold_reg && ext_reg != EXT_LAST + 1'b1) begin
      ext_next = ext_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      low_reg <= '0;
      ext_reg <= '0;
    end else begin
      low_reg <= low_next;
      ext_reg <= ext_next;
    end
  end

  // ******************************************************
  // alert gating
  // ******************************************************
  assign active = fault_reg & ~mask_reg & ~auto_reg;

  // ******************************************************
  // bus engine and masks
  // ******************************************************
  always_comb begin
    state_next = state_reg;
    ret_next = ret_reg;
    bit_next = bit_reg;
    byte_next = byte_reg;
    shift_next = shift_reg;
    cmd_next = cmd_reg;
    lo_next = lo_reg;
    mask_next = mask_reg;
    auto_next = auto_reg;
    sda_oe_next = sda_oe_reg;
    hold_next = hold_reg & busy_in;
    abort_next = 1'b0;
    fault_next = fault_in;
    alert_next = |active;
    own_addr_next = sat_pkg::decode_addr(pin_s2);
    case (state_reg)
      T_IDLE: begin
      end
      T_ADDR: begin
        if (scl_rise) begin
          shift_next = {shift_reg[6:0], sda_s2};
          bit_next = bit_reg + 4'h1;
        end
        if (scl_fall && bit_reg == 4'h8) begin
          if (shift_reg == {own_addr_reg, 1'b0}) begin
            sda_oe_next = 1'b1;
            ret_next = T_RX;
            state_next = T_ACK;
          end else if (shift_reg == {sat_pkg::ARA_ADDR, 1'b1} &&
                       alert_reg) begin
            sda_oe_next = 1'b1;
            ret_next = T_TX;
            state_next = T_ACK;
          end else begin
            state_next = T_SKIP;
          end
        end
      end
      T_ACK: begin
        if (scl_fall) begin
          bit_next = 4'h0;
          hold_next = busy_in;
          state_next = ret_reg;
          if (ret_reg == T_TX) begin
            shift_next = {own_addr_reg, 1'b1};
            sda_oe_next = ~own_addr_reg[6];
          end else begin
            sda_oe_next = 1'b0;
          end
        end
      end
      T_RX: begin
        if (scl_rise) begin
          shift_next = {shift_reg[6:0], sda_s2};
          bit_next = bit_reg + 4'h1;
        end
        if (scl_fall && bit_reg == 4'h8) begin
          sda_oe_next = 1'b1;
          ret_next = T_RX;
          state_next = T_ACK;
          if (byte_reg != 2'h3) begin
            byte_next = byte_reg + 2'h1;
          end
          case (byte_reg)
            2'h0: begin
              cmd_next = shift_reg;
              if (shift_reg == sat_pkg::CMD_CLEAR_FAULTS) begin
                auto_next = 16'h0000;
              end
            end
            2'h1: lo_next = shift_reg;
            2'h2: begin
              if (cmd_reg == sat_pkg::CMD_ALERT_MASK) begin
                mask_next = {shift_reg, lo_reg};
              end
            end
            default: begin
            end
          endcase
        end
      end
      T_TX: begin
        if (scl_rise) begin
          bit_next = bit_reg + 4'h1;
          // released a one but the bus reads zero: a lower address won
          if (!sda_oe_reg && !sda_s2) begin
            sda_oe_next = 1'b0;
            state_next = T_SKIP;
          end
        end
        if (scl_fall && state_next == T_TX) begin
          if (bit_reg == 4'h8) begin
            sda_oe_next = 1'b0;
            state_next = T_SKIP;
            auto_next = auto_reg | fault_reg;
          end else begin
            shift_next = {shift_reg[6:0], 1'b0};
            sda_oe_next = ~shift_reg[6];
          end
        end
      end
      T_SKIP: begin
      end
      default: state_next = T_IDLE;
    endcase
    if (start_det) begin
      state_next = T_ADDR;
      bit_next = 4'h0;
      byte_next = 2'h0;
      sda_oe_next = 1'b0;
      hold_next = 1'b0;
    end else if (stop_det) begin
      state_next = T_IDLE;
      sda_oe_next = 1'b0;
    end
    if (to_hit || ext_hit) begin
      state_next = T_IDLE;
      sda_oe_next = 1'b0;
      hold_next = 1'b0;
      abort_next = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_reg <= T_IDLE;
      ret_reg <= T_IDLE;
      bit_reg <= 4'h0;
      byte_reg <= 2'h0;
      shift_reg <= 8'h00;
      cmd_reg <= 8'h00;
      lo_reg <= 8'h00;
      mask_reg <= sat_pkg::ALERT_MASK_RESET;
      auto_reg <= 16'h0000;
      fault_reg <= 16'h0000;
      alert_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      hold_reg <= 1'b0;
      abort_reg <= 1'b0;
      own_addr_reg <= sat_pkg::TARGET_RESET;
    end else begin
      state_reg <= state_next;
      ret_reg <= ret_next;
      bit_reg <= bit_next;
      byte_reg <= byte_next;
      shift_reg <= shift_next;
      cmd_reg <= cmd_next;
      lo_reg <= lo_next;
      mask_reg <= mask_next;
      auto_reg <= auto_next;
      fault_reg <= fault_next;
      alert_reg <= alert_next;
      sda_oe_reg <= sda_oe_next;
      hold_reg <= hold_next;
      abort_reg <= abort_next;
      own_addr_reg <= own_addr_next;
    end
  end

  // ******************************************************
  // outputs
  // ******************************************************
  assign link.dev_scl_oe = hold_reg;
  assign link.dev_sda_oe = sda_oe_reg;
  assign link.dev_alert_oe = alert_reg;
  assign status_out = fault_reg;
  assign alert_mask_out = mask_reg;
  assign auto_mask_out = auto_reg;
  assign own_addr_out = own_addr_reg;
  assign bus_abort_out = abort_reg;

endmodule // sat_target

//--- hw/sat_host.sv
// host end: clock generation, byte sequencing, timeout and interrupt registers
`timescale 1ns/100ps
module sat_host #(
  parameter int TIMEOUT_CYC = sat_pkg::TIMEOUT_CYC
) (
  input logic clk_in,
  input logic rst_b_in,
  sat_link_if.host link,
  input logic [7:0] reg_addr_in,
  input logic [31:0] reg_wdata_in,
  input logic reg_wr_in,
  input logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  output logic irq_out
);

  // ******************************************************
  // types and state
  // ******************************************************
  typedef enum logic [5:0] {
    H_IDLE = 6'h01,
    H_START = 6'h02,
    H_LOW = 6'h04,
    H_HIGH = 6'h08,
    H_STOPA = 6'h10,
    H_STOPB = 6'h20
  } sat_hstate_type;

  localparam logic [7:0] HALF_LAST = 8'(sat_pkg::HALF_CYC - 1);
  localparam logic [7:0] QTR = 8'(sat_pkg::QTR_CYC);
  localparam logic [sat_pkg::CNT_W-1:0] TO_LAST =
    sat_pkg::CNT_W'(TIMEOUT_CYC - 1);

  function automatic logic [7:0] host_byte(input logic [1:0] op,
      input logic [1:0] idx, input logic [6:0] tgt, input logic [15:0] d);
    host_byte = 8'h00;
    if (op == sat_pkg::OP_ARA) begin
      host_byte = {sat_pkg::ARA_ADDR, 1'b1};
    end else begin
      case (idx)
        2'h0: host_byte = {tgt, 1'b0};
        2'h1: host_byte = (op == sat_pkg::OP_MASK) ?
                sat_pkg::CMD_ALERT_MASK : sat_pkg::CMD_CLEAR_FAULTS;
        2'h2: host_byte = d[7:0];
        default: host_byte = d[15:8];
      endcase
    end
  endfunction

  logic scl_s1, scl_s2, sda_s1, sda_s2, al_s1, al_s2, al_s3;
  sat_hstate_type state_reg, state_next;
  logic [7:0] cnt_reg, cnt_next;
  logic [3:0] bit_reg, bit_next;
  logic [1:0] byte_reg, byte_next, last_reg, last_next, op_reg, op_next;
  logic [7:0] tx_reg, tx_next, ara_reg, ara_next;
  logic [8:0] rx_reg, rx_next;
  logic scl_oe_reg, scl_oe_next, sda_oe_reg, sda_oe_next;
  logic [6:0] tgt_reg, tgt_next;
  logic [15:0] data_reg, data_next;
  logic [3:0] stat_reg, stat_next, imask_reg, imask_next, ev;
  logic [31:0] rdata_reg, rdata_next;
  logic [sat_pkg::CNT_W-1:0] low_reg, low_next;
  logic go, rd_last, wr_stat;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      {scl_s1, scl_s2, sda_s1, sda_s2} <= 4'hf;
      {al_s1, al_s2, al_s3} <= 3'h7;
    end else begin
      scl_s1 <= link.scl;
      scl_s2 <= scl_s1;
      sda_s1 <= link.sda;
      sda_s2 <= sda_s1;
      al_s1 <= link.alert_out_n;
      al_s2 <= al_s1;
      al_s3 <= al_s2;
    end
  end

  assign go = reg_wr_in && reg_addr_in == sat_pkg::HR_CMD &&
              state_reg == H_IDLE;
  assign rd_last = op_reg == sat_pkg::OP_ARA && byte_reg == last_reg;
  assign wr_stat = reg_wr_in && reg_addr_in == sat_pkg::HR_IRQ_STAT;

  // ******************************************************
  // bit and byte engine
  // ******************************************************
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg + 8'h01;
    bit_next = bit_reg;
    byte_next = byte_reg;
    last_next = last_reg;
    op_next = op_reg;
    tx_next = tx_reg;
    rx_next = rx_reg;
    ara_next = ara_reg;
    scl_oe_next = scl_oe_reg;
    sda_oe_next = sda_oe_reg;
    ev = 4'h0;
    low_next = scl_s2 ? '0 :
      (low_reg == TO_LAST + 1'b1) ? low_reg : low_reg + 1'b1;
    case (state_reg)
      H_IDLE: begin
        cnt_next = 8'h00;
        if (go) begin
          op_next = reg_wdata_in[1:0];
          last_next = (reg_wdata_in[1:0] == sat_pkg::OP_MASK) ? 2'h3 : 2'h1;
          byte_next = 2'h0;
          tx_next = host_byte(reg_wdata_in[1:0], 2'h0, tgt_reg, data_reg);
          sda_oe_next = 1'b1;
          state_next = H_START;
        end
      end
      H_START: begin
        if (cnt_reg == HALF_LAST) begin
          cnt_next = 8'h00;
          bit_next = 4'h0;
          scl_oe_next = 1'b1;
          state_next = H_LOW;
        end
      end
      H_LOW: begin
        if (cnt_reg == QTR) begin
          sda_oe_next = (bit_reg == 4'h8 || rd_last) ? 1'b0 : ~tx_reg[7];
        end
        if (cnt_reg == HALF_LAST) begin
          cnt_next = 8'h00;
          scl_oe_next = 1'b0;
          state_next = H_HIGH;
        end
      end
      H_HIGH: begin
        if (!scl_s2) begin
          cnt_next = 8'h00; // target stretch
        end else if (cnt_reg == QTR) begin
          rx_next = {rx_reg[7:0], sda_s2};
        end else if (cnt_reg == HALF_LAST) begin
          cnt_next = 8'h00;
          scl_oe_next = 1'b1;
          state_next = H_LOW;
          if (bit_reg != 4'h8) begin
            bit_next = bit_reg + 4'h1;
            tx_next = {tx_reg[6:0], 1'b0};
          end else if (!rd_last && rx_reg[0]) begin
            ev[sat_pkg::IRQ_NACK] = 1'b1;
            state_next = H_STOPA;
          end else if (byte_reg == last_reg) begin
            if (rd_last) begin
              ara_next = rx_reg[8:1];
            end
            state_next = H_STOPA;
          end else begin
            bit_next = 4'h0;
            byte_next = byte_reg + 2'h1;
            tx_next = host_byte(op_reg, byte_reg + 2'h1, tgt_reg, data_reg);
          end
        end
      end
      H_STOPA: begin
        if (cnt_reg == QTR) begin
          sda_oe_next = 1'b1;
        end
        if (cnt_reg == HALF_LAST) begin
          cnt_next = 8'h00;
          scl_oe_next = 1'b0;
          state_next = H_STOPB;
        end
      end
      H_STOPB: begin
        if (!scl_s2) begin
          cnt_next = 8'h00;
        end else if (cnt_reg == QTR) begin
          sda_oe_next = 1'b0;
        end else if (cnt_reg == HALF_LAST) begin
          ev[sat_pkg::IRQ_DONE] = 1'b1;
          state_next = H_IDLE;
        end
      end
      default: state_next = H_IDLE;
    endcase
    if (!scl_s2 && low_reg == TO_LAST) begin
      ev[sat_pkg::IRQ_TIMEOUT] = 1'b1;
      state_next = H_IDLE;
      scl_oe_next = 1'b0;
      sda_oe_next = 1'b0;
    end
    ev[sat_pkg::IRQ_ALERT] = al_s3 & ~al_s2;
  end

  // ******************************************************
  // register port and interrupt
  // ******************************************************
  always_comb begin
    tgt_next = tgt_reg;
    data_next = data_reg;
    imask_next = imask_reg;
    stat_next = (stat_reg & ~(wr_stat ? reg_wdata_in[3:0] : 4'h0)) | ev;
    rdata_next = 32'h0000_0000;
    if (reg_wr_in && reg_addr_in == sat_pkg::HR_DATA) begin
      data_next = reg_wdata_in[15:0];
    end
    if (reg_wr_in && reg_addr_in == sat_pkg::HR_TARGET) begin
      tgt_next = reg_wdata_in[6:0];
    end
    if (reg_wr_in && reg_addr_in == sat_pkg::HR_IRQ_MASK) begin
      imask_next = reg_wdata_in[3:0];
    end
    if (reg_rd_in) begin
      case (reg_addr_in)
        sat_pkg::HR_CMD: rdata_next = {31'h0, state_reg != H_IDLE};
        sat_pkg::HR_DATA: rdata_next = {8'h00, ara_reg, data_reg};
        sat_pkg::HR_TARGET: rdata_next = {25'h0, tgt_reg};
        sat_pkg::HR_IRQ_STAT: rdata_next = {28'h0, stat_reg};
        sat_pkg::HR_IRQ_MASK: rdata_next = {28'h0, imask_reg};
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_reg <= H_IDLE;
      cnt_reg <= 8'h00;
      bit_reg <= 4'h0;
      byte_reg <= 2'h0;
      last_reg <= 2'h0;
      op_reg <= 2'h0;
      tx_reg <= 8'h00;
      rx_reg <= 9'h000;
      ara_reg <= 8'h00;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      low_reg <= '0;
      tgt_reg <= sat_pkg::TARGET_RESET;
      data_reg <= 16'h0000;
      stat_reg <= 4'h0;
      imask_reg <= 4'h0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      bit_reg <= bit_next;
      byte_reg <= byte_next;
      last_reg <= last_next;
      op_reg <= op_next;
      tx_reg <= tx_next;
      rx_reg <= rx_next;
      ara_reg <= ara_next;
      scl_oe_reg <= scl_oe_next;
      sda_oe_reg <= sda_oe_next;
      low_reg <= low_next;
      tgt_reg <= tgt_next;
      data_reg <= data_next;
      stat_reg <= stat_next;
      imask_reg <= imask_next;
      rdata_reg <= rdata_next;
    end
  end

  assign link.host_scl_oe = scl_oe_reg;
  assign link.host_sda_oe = sda_oe_reg;
  assign reg_rdata_out = rdata_reg;
  assign irq_out = |(stat_reg & imask_reg);

endmodule // sat_host

//--- bench/sat_properties.sv
// assertions on the alert bus link and target status
`timescale 1ns/100ps
module sat_properties #(
  parameter int TIMEOUT_CYC = 2000,
  parameter int STRETCH_CYC = 3000
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_scl_oe,
  input wire logic dev_sda_oe,
  input wire logic dev_alert_oe,
  input wire logic [15:0] fault_in,
  input wire logic [15:0] status_out,
  input wire logic [15:0] alert_mask_out,
  input wire logic [15:0] auto_mask_out,
  input wire logic bus_abort_out
);
  localparam int MIN_HALF = sat_pkg::CLK_KHZ / (2 * sat_pkg::SCL_MAX_KHZ);
  logic [15:0] gate;
  int lo_cnt, hi_cnt, acc;
  assign gate = status_out & ~alert_mask_out & ~auto_mask_out;
  // low run, high run, stretch since start
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      lo_cnt <= 0;
      hi_cnt <= 0;
      acc <= 0;
    end else begin
      lo_cnt <= scl ? 0 : lo_cnt + 1;
      hi_cnt <= scl ? hi_cnt + 1 : 0;
      acc <= ($fell(sda) && scl) ? 0 : acc + int'(dev_scl_oe);
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  a_alert_raised:
    assert property ((|gate) [*2] |-> dev_alert_oe) else $error("no alert");
  a_alert_masked:
    assert property ((gate == 16'h0000) [*2] |-> !dev_alert_oe)
    else $error("alert while masked");
  a_status_copy:
    assert property (status_out == $past(fault_in)) else $error("status");
  a_auto_only_grows:
    assert property ($changed(auto_mask_out) |-> auto_mask_out == 16'h0000
      || (auto_mask_out & $past(auto_mask_out)) == $past(auto_mask_out))
    else $error("auto mask lost bits");
  a_auto_in_msg:
    assert property ($changed(auto_mask_out) |-> !scl)
    else $error("auto mask changed off bus");
  a_abort_release:
    assert property (bus_abort_out |-> ##2 (!dev_scl_oe && !dev_sda_oe))
    else $error("lines held after abort");
  a_clock_low_max:
    assert property (lo_cnt <= TIMEOUT_CYC + 16) else $error("clock low");
  a_stretch_total:
    assert property (acc <= STRETCH_CYC + 8) else $error("stretch total");
  a_scl_rate:
    assert property ($fell(scl) |-> hi_cnt >= MIN_HALF)
    else $error("clock too fast");
  c_ara_win: cover property ($rose(|auto_mask_out));
  c_abort: cover property (bus_abort_out);
  c_alert: cover property ($rose(dev_alert_oe));
endmodule // sat_properties

//--- bench/smbus_alert_and_timeout_bench.sv
// bench: masks, alert read, timeouts, stretch
`timescale 1ns/100ps
module smbus_alert_and_timeout_bench;
  localparam int TMO = 2000;
  localparam int STR = 3000;
  logic clk_in = 0, rst_b_in = 0, wr = 0, rs = 0, busy = 0, irq, abort;
  logic [7:0] ra = 0;
  logic [31:0] wd = 0, rdata, d;
  logic [15:0] flt = 0, stat, am, au, f, m;
  logic [1:0] p0 = 0, p1 = 0, p2 = 0;
  logic [6:0] own;
  int fails = 0, cmp_count = 0, n_ab = 0, k, a0;
  sat_link_if link();
  sat_host #(.TIMEOUT_CYC(TMO)) i_sat_host(.clk_in, .rst_b_in,
    .link(link.host), .reg_addr_in(ra), .reg_wdata_in(wd), .reg_wr_in(wr),
    .reg_rd_in(rs), .reg_rdata_out(rdata), .irq_out(irq));
  sat_target #(.TIMEOUT_CYC(TMO), .STRETCH_CYC(STR)) i_sat_target(
    .clk_in, .rst_b_in, .link(link.target), .fault_in(flt), .busy_in(busy),
    .addr_sel_pin0_in(p0), .addr_sel_pin1_in(p1), .addr_sel_pin2_in(p2),
    .status_out(stat), .alert_mask_out(am), .auto_mask_out(au),
    .own_addr_out(own), .bus_abort_out(abort));
  sat_properties #(.TIMEOUT_CYC(TMO), .STRETCH_CYC(STR)) i_sat_properties(
    .clk_in, .rst_b_in, .scl(link.scl), .sda(link.sda),
    .dev_scl_oe(link.dev_scl_oe), .dev_sda_oe(link.dev_sda_oe),
    .dev_alert_oe(link.dev_alert_oe), .fault_in(flt), .status_out(stat),
    .alert_mask_out(am), .auto_mask_out(au), .bus_abort_out(abort));
  always #20 clk_in = ~clk_in;
  always @(posedge clk_in) n_ab += int'(abort === 1'b1);
  task automatic chk(input bit ok);
    cmp_count++;
    if (!ok) begin
      fails++;
      $display("ERROR %0t: mismatch", $time);
    end
  endtask
  task automatic wr_r(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_in);
    ra <= a;
    wd <= v;
    wr <= 1;
    @(posedge clk_in);
    wr <= 0;
    @(posedge clk_in);
  endtask
  task automatic rd_r(input logic [7:0] a);
    @(posedge clk_in);
    ra <= a;
    rs <= 1;
    @(posedge clk_in);
    rs <= 0;
    @(posedge clk_in) d = rdata;
  endtask
  task automatic op(input logic [1:0] c);
    wr_r(sat_pkg::HR_CMD, {30'h0, c});
    d = 1;
    for (int i = 0; i < 30000 && d[0]; i++) rd_r(sat_pkg::HR_CMD);
    chk(d[0] === 1'b0);
  endtask
  // open pins get either open code at random
  function automatic logic [1:0] pc(input int v);
    return 2'(v == 0 ? 3 * $urandom_range(1, 0) : v);
  endfunction
  task automatic end_of_test();
    $display("compares %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clk_in);
    fails++;
    end_of_test();
  end
  initial begin
    void'($urandom(32'h01ea_ec20));
    repeat (6) @(posedge clk_in);
    rst_b_in <= 1;
    for (int n = 0; n < 28; n++) begin
      k = n < 27 ? n : $urandom_range(26, 0);
      p2 <= pc(k / 9);
      p1 <= pc(k / 3 % 3);
      p0 <= pc(k % 3);
      repeat (6) @(posedge clk_in);
      chk(own === sat_pkg::ADDR_TABLE[k]);
    end
    $display("address test done");
    wr_r(sat_pkg::HR_TARGET, {25'h0, sat_pkg::ADDR_TABLE[k]});
    wr_r(sat_pkg::HR_IRQ_MASK, 32'h4);
    m = 16'($urandom) & 16'h7ffe;
    f = 16'($urandom) & 16'h7fff | 16'h0001;
    flt <= f;
    wr_r(sat_pkg::HR_DATA, {16'h0, m});
    op(sat_pkg::OP_MASK);
    chk(am === m);
    chk(link.alert_out_n === 1'b0);
    chk(irq === 1'b1);
    wr_r(sat_pkg::HR_IRQ_MASK, 32'h0);
    chk(irq === 1'b0);
    wr_r(sat_pkg::HR_IRQ_STAT, 32'hf);
    wr_r(sat_pkg::HR_IRQ_MASK, 32'hf);
    chk(irq === 1'b0);
    rd_r(8'h20);
    chk(d === 32'h0);
    op(sat_pkg::OP_ARA);
    rd_r(sat_pkg::HR_DATA);
    chk(d[23:16] === {sat_pkg::ADDR_TABLE[k], 1'b1});
    chk(au === f);
    chk(link.alert_out_n === 1'b1);
    chk(stat === f);
    flt <= f | 16'h8000;
    repeat (4) @(posedge clk_in);
    chk(link.alert_out_n === 1'b0);
    op(sat_pkg::OP_CLEAR);
    chk(au === 16'h0);
    $display("alert test done");
    wr_r(sat_pkg::HR_IRQ_STAT, 32'hf);
    a0 = n_ab;
    busy <= 1;
    op(sat_pkg::OP_CLEAR);
    busy <= 0;
    rd_r(sat_pkg::HR_IRQ_STAT);
    chk(d[1] === 1'b1);
    chk(n_ab > a0);
    $display("timeout test done");
    wr_r(sat_pkg::HR_IRQ_STAT, 32'hf);
    wr_r(sat_pkg::HR_DATA, {16'h0, ~m});
    a0 = n_ab;
    fork
      op(sat_pkg::OP_MASK);
      repeat (3) begin
        busy <= 1;
        wait (link.dev_scl_oe);
        repeat (1100) @(posedge clk_in);
        busy <= 0;
        wait (!link.dev_scl_oe);
      end
    join
    rd_r(sat_pkg::HR_IRQ_STAT);
    chk(d[1] === 1'b0);
    chk(n_ab > a0);
    chk(am === m);
    $display("stretch test done");
    end_of_test();
  end
endmodule // smbus_alert_and_timeout_bench
